/* core/tncr_core.sv */
// two-level transmit and receive command chaining, resets, node id writes
// assumes commands and link events are one-cycle pulses on i_clk
`timescale 1ns/1ps
module tncr_core
  import tncr_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_hw_reset_n,
  // host register writes
  input  wire logic              i_cfg_we,
  input  wire logic [7:0]        i_cfg_wdata,
  input  wire logic              i_first_setup_reg_we,
  input  wire logic [7:0]        i_first_setup_reg_wdata,
  input  wire logic              i_nid_we,
  input  wire logic [7:0]        i_nid_wdata,
  input  wire logic              i_mask_tx,
  input  wire logic              i_mask_rx,
  // host commands
  input  wire logic [PAGE_W-1:0] i_cmd_page,
  input  wire logic              i_cmd_queue_tx,
  input  wire logic              i_cmd_queue_rx,
  input  wire logic              i_cmd_stop_tx,
  input  wire logic              i_cmd_stop_rx,
  input  wire logic              i_cmd_ack_tx,
  input  wire logic              i_cmd_ack_rx,
  // network engine events
  input  wire logic              i_token,
  input  wire logic              i_tx_done,
  input  wire logic              i_tx_acked,
  input  wire logic              i_rx_begin,
  input  wire logic              i_rx_done,
  // network engine control
  output logic                   o_tx_start,
  output logic [PAGE_W-1:0]      o_tx_page,
  output logic                   o_tx_busy,
  output logic                   o_rx_start,
  output logic [PAGE_W-1:0]      o_rx_page,
  output logic                   o_rx_busy,
  output logic                   o_tx_enable,
  // status
  output logic                   o_transmitter_available,
  output logic                   o_transmit_ack_flag,
  output logic                   o_tx_done_event,
  output logic                   o_receiver_inhibited,
  output logic                   o_rx_done_event,
  output logic                   o_irq,
  // configuration readback
  output logic [7:0]             o_cfg,
  output logic [7:0]             o_first_setup_reg,
  output logic [7:0]             o_node_id,
  output logic                   o_core_awake,
  output logic                   o_soft_reset,
  output logic                   o_chain_en,
  // buffer ram write port
  output logic                   o_ram_we,
  output logic [RAM_AW-1:0]      o_ram_addr,
  output logic [7:0]             o_ram_wdata
);

  // ***************************************************************
  // resets
  // ***************************************************************
  logic hw_rst;
  logic cfg_rst_n;
  logic core_rst_n;
  logic chain;

  tncr_rst_filt u_rst_filt (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_hw_reset_n (i_hw_reset_n),
    .o_hw_rst     (hw_rst)
  );

  // soft reset leaves config and setup alone, so they see only hard reset
  assign cfg_rst_n  = i_rst_n & ~hw_rst;
  assign core_rst_n = cfg_rst_n & ~o_cfg[CFG_SW_RST_BIT];
  assign chain      = o_cfg[CFG_CHAIN_BIT];

  always_ff @(posedge i_clk) begin
    if (!cfg_rst_n) begin
      o_cfg <= CFG_RST;
    end else if (i_cfg_we) begin
      o_cfg <= i_cfg_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!cfg_rst_n) begin
      o_first_setup_reg <= FIRST_SETUP_REG_RST;
    end else if (i_first_setup_reg_we) begin
      o_first_setup_reg <= i_first_setup_reg_wdata;
    end
  end

  // ***************************************************************
  // per-channel command queue and status buffer
  // ***************************************************************
  wire [1:0]        c_queue = {i_cmd_queue_rx, i_cmd_queue_tx};
  wire [1:0]        c_stop  = {i_cmd_stop_rx, i_cmd_stop_tx};
  wire [1:0]        c_ack   = {i_cmd_ack_rx, i_cmd_ack_tx};
  wire [1:0]        c_go    = {i_rx_begin, i_token};
  wire [1:0]        c_done  = {i_rx_done, i_tx_done};
  wire [1:0]        c_flag  = {1'b0, i_tx_acked};
  wire [1:0]        ch_avail;
  wire [1:0]        ch_event;
  wire [1:0]        ch_flag;
  wire [1:0]        ch_busy;
  wire [1:0]        ch_start;
  wire [PAGE_W-1:0] ch_page [2];

  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic [1:0]        q_v;
    logic [PAGE_W-1:0] q_pg [2];
    logic              busy;
    logic [1:0]        st_v;
    logic [1:0]        st_f;
    logic              live_f;
    logic [1:0]        next_q_v;
    logic [PAGE_W-1:0] next_q_pg0;
    logic [PAGE_W-1:0] next_q_pg1;
    logic              next_busy;
    logic [1:0]        next_st_v;
    logic [1:0]        next_st_f;
    logic              next_live_f;
    logic              fin;
    logic              pop;
    logic              go;

    assign fin = busy & c_done[g];
    // a started transfer cannot be withdrawn, so stop reaches the next one
    assign pop = fin | (c_stop[g] & q_v[0] & ~busy);
    assign go  = c_go[g] & q_v[0] & ~busy & ~c_stop[g];

    always_comb begin
      next_q_v    = q_v;
      next_q_pg0  = q_pg[0];
      next_q_pg1  = q_pg[1];
      next_busy   = busy;
      next_st_v   = st_v;
      next_st_f   = st_f;
      next_live_f = live_f;
      if (pop) begin
        next_q_v   = {1'b0, q_v[1]};
        next_q_pg0 = q_pg[1];
        next_busy  = 1'b0;
      end else if (c_stop[g] && q_v[1]) begin
        next_q_v[1] = 1'b0;
      end
      if (go) begin
        next_busy = 1'b1;
      end
      if (c_queue[g]) begin
        if (!next_q_v[0]) begin
          next_q_v[0] = 1'b1;
          next_q_pg0  = i_cmd_page;
          next_live_f = 1'b0;
        end else if (chain && !next_q_v[1]) begin
          next_q_v[1] = 1'b1;
          next_q_pg1  = i_cmd_page;
        end
      end
      // acknowledge shifts first, so a completion in that cycle is kept
      if (c_ack[g] && st_v[0]) begin
        next_st_v = {1'b0, st_v[1]};
        next_st_f = {1'b0, st_f[1]};
      end
      if (fin) begin
        next_live_f = c_flag[g];
        if (!next_st_v[0]) begin
          next_st_v[0] = 1'b1;
          next_st_f[0] = c_flag[g];
        end else begin
          next_st_v[1] = 1'b1;
          next_st_f[1] = c_flag[g];
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (!core_rst_n) begin
        q_v     <= '0;
        q_pg[0] <= '0;
        q_pg[1] <= '0;
        busy    <= 1'b0;
        live_f  <= 1'b0;
      end else begin
        q_v     <= next_q_v;
        q_pg[0] <= next_q_pg0;
        q_pg[1] <= next_q_pg1;
        busy    <= next_busy;
        live_f  <= next_live_f;
      end
    end

    // done events start clear and are set only by a finished transfer
    always_ff @(posedge i_clk) begin
      if (!core_rst_n) begin
        st_v <= '0;
        st_f <= '0;
      end else begin
        st_v <= next_st_v;
        st_f <= next_st_f;
      end
    end

    assign ch_avail[g] = ~q_v[0];
    assign ch_event[g] = st_v[0];
    assign ch_flag[g]  = chain ? st_f[0] : live_f;
    assign ch_busy[g]  = busy;
    assign ch_start[g] = go;
    assign ch_page[g]  = q_pg[0];
  end

  // ***************************************************************
  // link side and status outputs
  // ***************************************************************
  assign o_tx_start              = ch_start[CH_TX];
  assign o_tx_page               = ch_page[CH_TX];
  assign o_tx_busy               = ch_busy[CH_TX];
  assign o_rx_start              = ch_start[CH_RX];
  assign o_rx_page               = ch_page[CH_RX];
  assign o_rx_busy               = ch_busy[CH_RX];
  assign o_tx_enable             = o_cfg[CFG_TX_EN_BIT] & core_rst_n;
  assign o_transmitter_available = ch_avail[CH_TX];
  assign o_transmit_ack_flag     = ch_flag[CH_TX];
  assign o_tx_done_event         = ch_event[CH_TX];
  assign o_receiver_inhibited    = ch_avail[CH_RX];
  assign o_rx_done_event         = ch_event[CH_RX];
  assign o_soft_reset            = o_cfg[CFG_SW_RST_BIT];
  assign o_chain_en              = chain;
  assign o_core_awake            = o_node_id != NODE_ID_RST;

  // ***************************************************************
  // interrupt
  // ***************************************************************
  logic [1:0] mask;
  logic       irq_req;
  logic       irq_drop;

  assign mask = {i_mask_rx, i_mask_tx};

  // chaining masks the done events, otherwise the live available bits
  assign irq_req  = chain ? |(ch_event & mask)
                          : |(ch_avail & mask);
  assign irq_drop = chain & |(c_ack & ch_event);

  tncr_irq_space u_irq_space (
    .i_clk   (i_clk),
    .i_rst_n (core_rst_n),
    .i_req   (irq_req),
    .i_drop  (irq_drop),
    .o_irq   (o_irq)
  );

  // ***************************************************************
  // node identifier and wake-up ram writes
  // ***************************************************************
  tncr_ram_st_t ram_st;

  always_ff @(posedge i_clk) begin
    if (!core_rst_n) begin
      o_node_id <= NODE_ID_RST;
    end else if (i_nid_we) begin
      o_node_id <= i_nid_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!core_rst_n) begin
      ram_st      <= TNCR_RAM_IDLE;
      o_ram_we    <= 1'b0;
      o_ram_addr  <= '0;
      o_ram_wdata <= '0;
    end else begin
      o_ram_we <= 1'b0;
      case (ram_st)
        TNCR_RAM_IDLE: begin
          if (i_nid_we) begin
            ram_st <= TNCR_RAM_MARK;
          end
        end
        TNCR_RAM_MARK: begin
          o_ram_we    <= 1'b1;
          o_ram_addr  <= RAM_MARK_ADDR;
          o_ram_wdata <= RAM_MARK;
          ram_st      <= TNCR_RAM_NID;
        end
        TNCR_RAM_NID: begin
          o_ram_we    <= 1'b1;
          o_ram_addr  <= RAM_NID_ADDR;
          o_ram_wdata <= o_node_id;
          ram_st      <= TNCR_RAM_IDLE;
        end
        default: begin
          ram_st <= TNCR_RAM_IDLE;
        end
      endcase
    end
  end

endmodule // tncr_core

/* core/tncr_irq_space.sv */
// interrupt output with a guaranteed inactive gap between interrupts
// assumes i_drop is a one-cycle acknowledge pulse
`timescale 1ns/1ps
module tncr_irq_space
  import tncr_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // request and acknowledge
  input  wire logic i_req,
  input  wire logic i_drop,
  output logic      o_irq
);

  logic [GAP_CNT_W-1:0] gap;
  logic                 load;

  // an acknowledge forces a low gap even when another source still asks
  assign load = o_irq & (i_drop | ~i_req);

  // ***************************************************************
  // gap counter and output
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gap <= '0;
    end else if (load) begin
      gap <= IRQ_GAP_CYC;
    end else if (gap != '0) begin
      gap <= gap - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= i_req & ~load & (gap == '0);
    end
  end

endmodule // tncr_irq_space

/* core/tncr_pkg.sv */
// constants shared by the command chaining and reset block
// assumes a single 125 MHz clock; link events arrive as one-cycle pulses
package tncr_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS     = 8;
  // crystal period is not fixed here; plain default of a 20 MHz crystal
  localparam int CRYSTAL_PERIOD_NS = 50;
  localparam int HW_RST_MIN_XTAL   = 5;
  localparam int HW_RST_MIN_NS     = HW_RST_MIN_XTAL * CRYSTAL_PERIOD_NS;
  localparam int HW_RST_MIN_CYC    = (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W         = 6;
  localparam logic [RST_CNT_W-1:0] HW_RST_LAST = RST_CNT_W'(HW_RST_MIN_CYC - 1);
  localparam int IRQ_GAP_NS        = 200;
  localparam int IRQ_GAP_CYC_I     = (IRQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CNT_W         = 5;
  localparam logic [GAP_CNT_W-1:0] IRQ_GAP_CYC = GAP_CNT_W'(IRQ_GAP_CYC_I);

  // ***************************************************************
  // configuration fields and reset values
  // ***************************************************************
  localparam int         CFG_SW_RST_BIT = 7;
  localparam int         CFG_CHAIN_BIT  = 6;
  localparam int         CFG_TX_EN_BIT  = 5;
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [7:0] FIRST_SETUP_REG_RST     = 8'h00;
  localparam logic [7:0] NODE_ID_RST    = 8'h00;
  localparam int         PAGE_W         = 3;

  // ***************************************************************
  // buffer ram writes after a node identifier write
  // ***************************************************************
  localparam int          RAM_AW        = 11;
  localparam logic [7:0]  RAM_MARK      = 8'hd1;
  localparam logic [10:0] RAM_MARK_ADDR = 11'h000;
  localparam logic [10:0] RAM_NID_ADDR  = 11'h001;

  // channel index: 0 transmit, 1 receive
  localparam int CH_TX = 0;
  localparam int CH_RX = 1;

  typedef enum logic [1:0] {
    TNCR_RAM_IDLE,
    TNCR_RAM_MARK,
    TNCR_RAM_NID
  } tncr_ram_st_t;

endpackage

/* core/tncr_rst_filt.sv */
// glitch filter on the hardware reset pin
// assumes the pin is already synchronous to i_clk
`timescale 1ns/1ps
module tncr_rst_filt
  import tncr_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // pin and filtered reset
  input  wire logic i_hw_reset_n,
  output logic      o_hw_rst
);

  logic [RST_CNT_W-1:0] low_cnt;

  // ***************************************************************
  // low must persist the full minimum before reset is taken
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_hw_reset_n) begin
      low_cnt  <= '0;
      o_hw_rst <= 1'b0;
    end else if (low_cnt != HW_RST_LAST) begin
      low_cnt <= low_cnt + 1'b1;
    end else begin
      o_hw_rst <= 1'b1;
    end
  end

endmodule // tncr_rst_filt

/* testbench/tb_tncr_core.sv */
// self-checking bench for the chaining and reset block
// assumes the engine model finishes each started transfer by itself
`timescale 1ns/1ps
module tb_tncr_core
  import tncr_pkg::*;
;
  // ***************************************************************
  // stimulus and observation
  // ***************************************************************
  logic              i_clk       = 1'b0;
  logic              i_rst_n     = 1'b0;
  logic              hw_n        = 1'b1;
  // masks start closed: with chaining off the empty queues would raise the interrupt
  logic              mtx         = 1'b0;
  logic              mrx         = 1'b0;
  logic              ackv        = 1'b1;
  logic [10:0]       st          = 11'h000;
  logic [7:0]        wd          = 8'h00;
  logic [PAGE_W-1:0] pg          = 3'h0;
  int                num_errors  = 0;
  int                checks_done = 0;
  int                cyc         = 0;
  wire               tx_start, rx_start, tx_done, tx_acked, rx_done, avail, flag, tev;
  wire               inh, rev, irq, chain, txen, awake;
  wire [PAGE_W-1:0]  txp, rxp;
  wire [7:0]         cfg, su, nid;
  wire [2:0]         w = {irq, tev, rev};

  tncr_core u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hw_reset_n(hw_n),
    .i_cfg_we(st[0]), .i_cfg_wdata(wd), .i_first_setup_reg_we(st[1]), .i_first_setup_reg_wdata(wd),
    .i_nid_we(st[2]), .i_nid_wdata(wd), .i_mask_tx(mtx), .i_mask_rx(mrx),
    .i_cmd_page(pg), .i_cmd_queue_tx(st[3]), .i_cmd_queue_rx(st[4]), .i_cmd_stop_tx(st[5]),
    .i_cmd_stop_rx(st[6]), .i_cmd_ack_tx(st[7]), .i_cmd_ack_rx(st[8]), .i_token(st[9]),
    .i_tx_done(tx_done), .i_tx_acked(tx_acked), .i_rx_begin(st[10]), .i_rx_done(rx_done),
    .o_tx_start(tx_start), .o_tx_page(txp), .o_tx_busy(), .o_rx_start(rx_start),
    .o_rx_page(rxp), .o_rx_busy(), .o_tx_enable(txen), .o_transmitter_available(avail),
    .o_transmit_ack_flag(flag), .o_tx_done_event(tev), .o_receiver_inhibited(inh),
    .o_rx_done_event(rev), .o_irq(irq), .o_cfg(cfg), .o_first_setup_reg(su),
    .o_node_id(nid), .o_core_awake(awake), .o_soft_reset(), .o_chain_en(chain),
    .o_ram_we(), .o_ram_addr(), .o_ram_wdata()
  );
  tncr_net_model u_net (
    .i_clk(i_clk), .i_tx_start(tx_start), .i_rx_start(rx_start), .i_ack_val(ackv),
    .o_tx_done(tx_done), .o_tx_acked(tx_acked), .o_rx_done(rx_done)
  );

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // one pulse on strobe k, taken at the second edge; ends just after it
  task automatic cmd(input int k, input logic [7:0] v);
    @(posedge i_clk);
    wd <= v;
    pg <= v[PAGE_W-1:0];
    st[k] <= 1'b1;
    @(posedge i_clk);
    st[k] <= 1'b0;
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait; the interrupt gap may delay a rise by some 26 cycles
  task automatic wfor(input int k, input logic v);
    int n;
    n = 0;
    while (w[k] !== v && n < 200) begin
      idle(1);
      n++;
    end
    chk(w[k], v);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    idle(1);
    chk({avail, inh, irq, chain, txen}, 12'h18);
    @(posedge i_clk) mtx <= 1'b1;
    idle(2);
    chk(irq, 12'h1);
    @(posedge i_clk) mtx <= 1'b0;
    idle(2);
    chk(irq, 12'h0);
    cmd(1, 8'h05);
    cmd(2, 8'h2a);
    chk({awake, nid}, 12'h12a);
    cmd(0, 8'h60);
    chk({chain, txen, cfg}, 12'h360);
    @(posedge i_clk) begin
      mtx <= 1'b1;
      mrx <= 1'b1;
    end
    $display("test setup done");
    cmd(3, 8'h02);
    chk({avail, flag}, 12'h0);
    cmd(3, 8'h05);
    cmd(9, 8'h00);
    wfor(1, 1'b1);
    wfor(2, 1'b1);
    chk({flag, txp}, 12'hd);
    ackv <= 1'b0;
    cmd(9, 8'h00);
    idle(12);
    chk({tev, flag, irq}, 12'h7);
    cmd(7, 8'h00);
    chk({tev, flag, irq}, 12'h4);
    wfor(2, 1'b1);
    cmd(7, 8'h00);
    chk({tev, irq, avail}, 12'h1);
    $display("test tx chain done");
    cmd(3, 8'h01);
    cmd(3, 8'h03);
    cmd(5, 8'h00);
    chk({avail, txp}, 12'h3);
    cmd(5, 8'h00);
    chk(avail, 12'h1);
    $display("test tx stop done");
    @(posedge i_clk) mtx <= 1'b0;
    cmd(3, 8'h04);
    cmd(9, 8'h00);
    wfor(1, 1'b1);
    idle(30);
    chk({irq, avail}, 12'h1);
    @(posedge i_clk) mtx <= 1'b1;
    wfor(2, 1'b1);
    cmd(7, 8'h00);
    chk({tev, irq}, 12'h0);
    $display("test tx mask done");
    cmd(4, 8'h01);
    cmd(4, 8'h04);
    chk(inh, 12'h0);
    cmd(10, 8'h00);
    wfor(0, 1'b1);
    wfor(2, 1'b1);
    cmd(10, 8'h00);
    idle(12);
    chk({rev, irq, inh}, 12'h7);
    cmd(8, 8'h00);
    chk({rev, irq}, 12'h2);
    wfor(2, 1'b1);
    cmd(8, 8'h00);
    chk({rev, irq, inh}, 12'h1);
    $display("test rx chain done");
    cmd(4, 8'h02);
    cmd(4, 8'h06);
    cmd(10, 8'h00);
    cmd(6, 8'h00);
    chk({inh, rxp}, 12'h2);
    wfor(0, 1'b1);
    chk(inh, 12'h1);
    cmd(8, 8'h00);
    cmd(4, 8'h03);
    cmd(4, 8'h05);
    cmd(6, 8'h00);
    chk({inh, rxp}, 12'h5);
    cmd(6, 8'h00);
    chk(inh, 12'h1);
    $display("test rx stop done");
    cmd(3, 8'h07);
    cmd(0, 8'he0);
    idle(2);
    chk({avail, txen, cfg}, 12'h2e0);
    chk(su, 12'h05);
    cmd(0, 8'h60);
    chk({txen, cfg}, 12'h160);
    $display("test soft reset done");
    @(posedge i_clk) hw_n <= 1'b0;
    idle(20);
    @(posedge i_clk) hw_n <= 1'b1;
    idle(2);
    chk(cfg, 12'h60);
    @(posedge i_clk) hw_n <= 1'b0;
    idle(40);
    @(posedge i_clk) hw_n <= 1'b1;
    idle(2);
    chk({avail, txen, cfg}, 12'h200);
    $display("test hard reset done");
    report_and_stop();
  end
endmodule // tb_tncr_core

/* testbench/tncr_core_assertions.sv */
// port-level assertions for the chaining and reset block
// assumes it is bound to tncr_core and shares its clock and reset
`timescale 1ns/1ps
module tncr_core_chk
  import tncr_pkg::*;
(
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_hw_reset_n,
  // host side
  input wire logic              i_cfg_we,
  input wire logic              i_nid_we,
  input wire logic [7:0]        i_nid_wdata,
  input wire logic              i_mask_tx,
  input wire logic              i_mask_rx,
  input wire logic              i_cmd_queue_tx,
  input wire logic              i_cmd_ack_tx,
  input wire logic              i_cmd_ack_rx,
  // engine side
  input wire logic              i_tx_done,
  input wire logic              i_rx_done,
  input wire logic              o_tx_busy,
  input wire logic              o_rx_busy,
  input wire logic              o_tx_enable,
  // status
  input wire logic              o_transmitter_available,
  input wire logic              o_transmit_ack_flag,
  input wire logic              o_tx_done_event,
  input wire logic              o_receiver_inhibited,
  input wire logic              o_rx_done_event,
  input wire logic              o_irq,
  input wire logic              o_soft_reset,
  input wire logic              o_chain_en,
  // buffer ram
  input wire logic              o_ram_we,
  input wire logic [RAM_AW-1:0] o_ram_addr,
  input wire logic [7:0]        o_ram_wdata
);
  // ***************************************************************
  // helpers
  // ***************************************************************
  // no reset is active or being written this cycle
  wire        ok      = i_hw_reset_n && !o_soft_reset && !i_cfg_we;
  wire        okm     = ok && i_rst_n && o_chain_en && i_mask_tx && i_mask_rx;
  wire        ack_any = i_cmd_ack_tx || i_cmd_ack_rx;
  logic [4:0] low_cnt;
  // saturated after i_rst_n or soft reset so the first interrupt is not judged
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || o_soft_reset) begin
      low_cnt <= 5'h1f;
    end else if (o_irq) begin
      low_cnt <= 5'h00;
    end else if (low_cnt != 5'h1f) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_q_tx;
    ok && o_chain_en && i_cmd_queue_tx && o_transmitter_available && !o_tx_done_event
      |=> !o_transmitter_available && !o_transmit_ack_flag;
  endproperty
  a_q_tx: assert property (p_q_tx)
    else $error("queue left tx status set");
  property p_tx_set;
    ok && o_chain_en && i_tx_done && o_tx_busy |=> o_tx_done_event;
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("tx done event missing");
  property p_tx_hold;
    ok && o_tx_done_event && !i_cmd_ack_tx |=> o_tx_done_event;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx done event lost");
  property p_rx_set;
    ok && o_chain_en && i_rx_done && o_rx_busy |=> o_rx_done_event;
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("rx done event missing");
  property p_rx_hold;
    ok && o_rx_done_event && !i_cmd_ack_rx |=> o_rx_done_event;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("rx done event lost");
  property p_irq_drop;
    $fell(o_irq) && $past(okm) |-> $past(ack_any);
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("irq fell without acknowledge");
  property p_gap;
    $rose(o_irq) |-> low_cnt >= 5'd25;
  endproperty
  a_gap: assert property (p_gap)
    else $error("irq inactive gap too short");
  property p_ram;
    i_nid_we && ok |=> ##1 (o_ram_we && o_ram_addr == RAM_MARK_ADDR && o_ram_wdata == RAM_MARK)
      ##1 (o_ram_we && o_ram_addr == RAM_NID_ADDR && o_ram_wdata == $past(i_nid_wdata, 3));
  endproperty
  a_ram: assert property (p_ram)
    else $error("node id ram writes wrong");
  property p_rst;
    !$past(i_rst_n) |-> !o_chain_en && o_transmitter_available && o_receiver_inhibited
      && !o_irq && !o_tx_enable && !o_tx_done_event;
  endproperty
  a_rst: assert property (p_rst)
    else $error("state after reset wrong");
  property p_soft;
    o_soft_reset && !i_cfg_we |=> o_transmitter_available && !o_tx_enable;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset not holding");
endmodule // tncr_core_chk

bind tncr_core tncr_core_chk u_chk (
  .i_clk, .i_rst_n, .i_hw_reset_n, .i_cfg_we, .i_nid_we, .i_nid_wdata, .i_mask_tx,
  .i_mask_rx, .i_cmd_queue_tx, .i_cmd_ack_tx, .i_cmd_ack_rx, .i_tx_done, .i_rx_done,
  .o_tx_busy, .o_rx_busy, .o_tx_enable, .o_transmitter_available, .o_transmit_ack_flag,
  .o_tx_done_event, .o_receiver_inhibited, .o_rx_done_event, .o_irq, .o_soft_reset,
  .o_chain_en, .o_ram_we, .o_ram_addr, .o_ram_wdata
);

/* testbench/tncr_net_model.sv */
// network engine stand-in: ends each started transfer after a delay
// assumes start pulses come from the block under test on i_clk
`timescale 1ns/1ps
module tncr_net_model #(
  parameter int DLY = 6
) (
  input  wire logic i_clk,
  input  wire logic i_tx_start,
  input  wire logic i_rx_start,
  input  wire logic i_ack_val,
  output logic      o_tx_done  = 1'b0,
  output logic      o_tx_acked = 1'b0,
  output logic      o_rx_done  = 1'b0
);
  int tx_cnt = 0;
  int rx_cnt = 0;
  always @(posedge i_clk) begin
    o_tx_done  <= (tx_cnt == 1);
    // ack only means something beside done, so it toggles otherwise
    o_tx_acked <= (tx_cnt == 1) ? i_ack_val : !o_tx_acked;
    o_rx_done  <= (rx_cnt == 1);
    tx_cnt     <= i_tx_start ? DLY : ((tx_cnt > 0) ? tx_cnt - 1 : 0);
    rx_cnt     <= i_rx_start ? DLY : ((rx_cnt > 0) ? rx_cnt - 1 : 0);
  end
endmodule // tncr_net_model
